// ===== rtl/ctpdm_map.svh
`ifndef CTPDM_MAP_SVH
`define CTPDM_MAP_SVH

// register index of the trim value; byte address is four times the index
`define CTPDM_TRIM_IDX      8'ha6
`define CTPDM_TRIM_ADDR     10'h298
`define CTPDM_TRIM_RESET    16'h8000
`define CTPDM_TRIM_LSB      0
`define CTPDM_TRIM_MSB      15
// the modulator steps once every sixteen system clocks
`define CTPDM_TICK_DIV      16
// value returned for an unmapped read
`define CTPDM_UNMAPPED_DATA 32'h0000_0000

`endif

// ===== rtl/ctpdm_pkg.sv
`default_nettype none
package ctpdm_pkg;
  // one avalon request as seen by the slave
  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ctpdm_req_s;

  typedef logic [15:0] ctpdm_trim_t;
endpackage
`default_nettype wire

// ===== rtl/ctpdm_accum.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctpdm_map.svh"
module ctpdm_accum
  import ctpdm_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // step strobe and value
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] level,
  // modulated bit
  output logic                  bit_out
);
  logic [WIDTH-1:0] acc;
  logic [WIDTH-1:0] next_acc;
  logic             next_bit;
  logic [WIDTH:0]   sum;

  // first-order modulator: carry of the sum becomes the output bit
  always_comb begin
    sum      = {1'b0, acc} + {1'b0, level};
    next_acc = acc;
    next_bit = bit_out;
    if (tick) begin
      next_acc = sum[WIDTH-1:0];
      next_bit = sum[WIDTH];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc     <= '0;
      bit_out <= 1'b0;
    end else begin
      acc     <= next_acc;
      bit_out <= next_bit;
    end
  end

  // output only moves on a tick
  chk_bit_holds: assert property (@(posedge clk) disable iff (!resetn)
    !$past(tick) |-> $stable(bit_out))
    else $error("modulator bit changed without a tick");

  // carry drives the bit one cycle after the tick
  chk_carry_out: assert property (@(posedge clk) disable iff (!resetn)
    tick |=> bit_out == $past(sum[WIDTH]))
    else $error("output bit is not the accumulator carry");
endmodule
`default_nettype wire

// ===== rtl/ctpdm_top.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ctpdm_map.svh"
module ctpdm_top
  import ctpdm_pkg::*;
#(
  parameter int TICK_DIV = `CTPDM_TICK_DIV
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // crystal trim pin
  output logic             crystal_tune_value
);
  localparam int CW       = $clog2(TICK_DIV);
  // clocks between two ticks, as a plain constant for sequence delays
  localparam int TICK_GAP = TICK_DIV - 1;

  ctpdm_req_s       req;
  ctpdm_trim_t      trim_level;
  ctpdm_trim_t      next_trim_level;
  logic [31:0]      next_readdata;
  logic             ack;
  logic             next_ack;
  logic [CW-1:0]    div_cnt;
  logic [CW-1:0]    next_div_cnt;
  logic             tick;
  logic             pdm_bit;
  logic [7:0]       since_tick;
  logic [7:0]       next_since_tick;

  // decode shared by read and write paths
  function automatic logic hit_trim(input logic [9:0] a);
    hit_trim = (a == `CTPDM_TRIM_ADDR);
  endfunction

  assign req = '{avs_address, avs_read, avs_write, avs_writedata,
                 avs_byteenable};

  // every access waits one cycle; the ack cycle completes it
  assign avs_waitrequest = (req.read | req.write) & ~ack;

  // register write, byte lanes honoured, and read data
  always_comb begin
    next_trim_level = trim_level;
    next_readdata   = avs_readdata;
    next_ack        = 1'b0;
    if ((req.read | req.write) && !ack) begin
      next_ack = 1'b1;
      if (req.write && hit_trim(req.address)) begin
        if (req.byteenable[0])
          next_trim_level[7:0] = req.writedata[7:0];
        if (req.byteenable[1])
          next_trim_level[15:8] = req.writedata[15:8];
      end
      if (req.read) begin
        if (hit_trim(req.address))
          next_readdata = {16'h0000, trim_level};
        else
          next_readdata = `CTPDM_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trim_level   <= `CTPDM_TRIM_RESET;
      avs_readdata <= 32'h0000_0000;
      ack          <= 1'b0;
    end else begin
      trim_level   <= next_trim_level;
      avs_readdata <= next_readdata;
      ack          <= next_ack;
    end
  end

  // free-running divider; a tick every TICK_DIV clocks
  always_comb begin
    tick         = (div_cnt == CW'(TICK_DIV - 1));
    next_div_cnt = tick ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      div_cnt <= '0;
    else
      div_cnt <= next_div_cnt;
  end

  // check helper: clocks since the last tick, saturating so that a stuck
  // divider cannot wrap round and pass the spacing check by chance
  always_comb begin
    next_since_tick = since_tick;
    if (tick)
      next_since_tick = 8'h00;
    else if (since_tick != 8'hff)
      next_since_tick = since_tick + 8'h01;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      since_tick <= 8'h00;
    else
      since_tick <= next_since_tick;
  end

  // the stored value is fed straight in, so a write takes effect next tick
  ctpdm_accum #(
    .WIDTH (16)
  ) u_accum (
    .clk     (clk),
    .resetn  (resetn),
    .tick    (tick),
    .level   (trim_level),
    .bit_out (pdm_bit)
  );

  // pin comes from the modulator flop; filtered externally
  assign crystal_tune_value = pdm_bit;

  // a full 65536-tick duty count is far too long for a property, so the
  // scale is checked bit by bit at its two ends and at its middle
  // a zero value never carries, so the bit after any tick is low
  chk_zero_duty: assert property (@(posedge clk) disable iff (!resetn)
    (tick && trim_level == 16'h0000) |=> !crystal_tune_value)
    else $error("zero trim value produced a high output");

  // midscale flips the accumulator top bit each tick, so bits alternate
  sequence s_mid_pair;
    (tick && trim_level == 16'h8000) ##TICK_DIV
    (tick && trim_level == 16'h8000);
  endsequence

  chk_mid_alt: assert property (@(posedge clk) disable iff (!resetn)
    s_mid_pair |=> crystal_tune_value != $past(crystal_tune_value, TICK_DIV))
    else $error("midscale value did not give alternating bits");

  // all ones gives one low bit per 65536 ticks, never two in a row
  sequence s_full_pair;
    (tick && trim_level == 16'hffff) ##TICK_DIV
    (tick && trim_level == 16'hffff);
  endsequence

  chk_full_duty: assert property (@(posedge clk) disable iff (!resetn)
    s_full_pair |=> crystal_tune_value || $past(crystal_tune_value, TICK_DIV))
    else $error("full trim value gave two low bits in a row");

  // between ticks the pin must hold its level for the external filter
  chk_pin_steady: assert property (@(posedge clk) disable iff (!resetn)
    !tick |=> $stable(crystal_tune_value))
    else $error("trim pin moved between ticks");

  // one tick, a quiet clock after it, then the next tick exactly TICK_DIV on
  sequence s_tick_pair;
    !tick ##TICK_GAP tick;
  endsequence

  chk_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
    tick |=> s_tick_pair)
    else $error("tick spacing does not match the divider");

  // the helper count catches a tick that comes before its time
  chk_tick_seq: assert property (@(posedge clk) disable iff (!resetn)
    tick |-> since_tick == 8'(TICK_GAP))
    else $error("tick followed by another tick too early");

  // a full-word write is stored by the time the access completes
  chk_trim_write: assert property (@(posedge clk) disable iff (!resetn)
    (req.write && !avs_waitrequest && hit_trim(req.address)
     && req.byteenable[1:0] == 2'b11)
    |=> trim_level == $past(req.writedata[15:0]))
    else $error("trim write did not store the value");

  // read data are ready in the cycle in which waitrequest drops
  chk_trim_read: assert property (@(posedge clk) disable iff (!resetn)
    (req.read && !ack && hit_trim(req.address))
    |=> !avs_waitrequest && avs_readdata == {16'h0000, $past(trim_level)})
    else $error("trim read returned a wrong value");

  // every request sees exactly one wait cycle
  chk_wait_one: assert property (@(posedge clk) disable iff (!resetn)
    ((req.read | req.write) && !ack) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not released after one cycle");

  // a write with the upper lane off must leave the upper byte alone
  chk_lane_keep: assert property (@(posedge clk) disable iff (!resetn)
    (req.write && !ack && hit_trim(req.address) && !req.byteenable[1])
    |=> trim_level[15:8] == $past(trim_level[15:8]))
    else $error("disabled byte lane changed the trim value");

  // writes elsewhere in the map must not disturb the trim value
  chk_unmap_write: assert property (@(posedge clk) disable iff (!resetn)
    (req.write && !ack && !hit_trim(req.address)) |=> $stable(trim_level))
    else $error("unmapped write changed the trim value");

  // unmapped reads answer with the fixed filler word
  chk_unmap_read: assert property (@(posedge clk) disable iff (!resetn)
    (req.read && !ack && !hit_trim(req.address))
    |=> avs_readdata == `CTPDM_UNMAPPED_DATA)
    else $error("unmapped read returned nonzero data");

  // read data hold until the next read, so a slow master still sees them
  chk_read_holds: assert property (@(posedge clk) disable iff (!resetn)
    !(req.read && !ack) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

// ===== bench/ctpdm_xtal.sv
`timescale 1ns/1ps
`default_nettype none
// varicap stand-in: integrates time spent high, in place of the rc node
module ctpdm_xtal (
  // clock and control
  input  wire logic   clk,
  input  wire logic   clr,
  // trim pin
  input  wire logic   tune,
  output logic [15:0] high_cnt
);
  // no droop modelled, so a window count is the filtered level
  always_ff @(posedge clk) high_cnt <= clr ? 16'h0 : high_cnt + 16'(tune);
endmodule
`default_nettype wire

// ===== bench/crystal_trim_pdm_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctpdm_map.svh"
module crystal_trim_pdm_tb;
  import ctpdm_pkg::*;
  // short divider keeps each duty window near a thousand clocks
  localparam int TD = 4;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        clr = 1'b1;
  logic        pin;
  logic        wait_rq;
  logic [9:0]  adr = 10'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] e;
  logic [3:0]  be = 4'h0;
  logic [15:0] hc;
  logic [31:0] exp_q[$];
  int          miscompares = 0;
  int          n_tests = 0;
  int          seed = 33;
  // 50 ns period
  always #25 clk = ~clk;
  ctpdm_top #(.TICK_DIV(TD)) i_dut (.clk(clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_rq),
    .crystal_tune_value(pin));
  ctpdm_xtal i_xtal (.clk(clk), .clr(clr), .tune(pin), .high_cnt(hc));
  // avalon cycle; request holds until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    be <= b;
    @(posedge clk);
    while (wait_rq !== 1'b0) @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  // reply data stand at the completing edge, so they are taken there
  always @(posedge clk) begin
    if (rd === 1'b1 && wait_rq === 1'b0) begin
      e = exp_q.pop_front();
      n_tests++;
      if (rdat !== e) begin
        miscompares++;
        $display("CHECK FAILED readdata exp %h got %h", e, rdat);
      end
    end
  end
  // window of 256 ticks; tolerance covers tick phase at both ends
  task automatic duty(input logic [15:0] v);
    int x;
    bus(1'b1, `CTPDM_TRIM_ADDR, {16'h0, v}, 4'h3);
    repeat (2*TD) @(posedge clk);
    clr <= 1'b0;
    repeat (256*TD) @(posedge clk);
    clr <= 1'b1;
    x = int'(v) * TD / 256;
    @(negedge clk);
    n_tests++;
    if (int'(hc) > x + 2*TD || int'(hc) + 2*TD < x) begin
      miscompares++;
      $display("CHECK FAILED high_cycles exp %0d got %0d", x, hc);
    end
    $display("duty test %h done", v);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(`CTPDM_TRIM_ADDR, 32'h8000);
    duty(16'h8000);
    bus(1'b1, `CTPDM_TRIM_ADDR, 32'h0000ffff, 4'hf);
    rd_chk(`CTPDM_TRIM_ADDR, 32'hffff);
    bus(1'b1, `CTPDM_TRIM_ADDR, 32'h1234, 4'h1);
    bus(1'b1, 10'h29c, 32'h0000_5678, 4'hf);
    rd_chk(`CTPDM_TRIM_ADDR, 32'hff34);
    rd_chk(10'h29c, 32'h0);
    $display("register test done");
    duty(16'h0000);
    duty(16'hffff);
    duty(16'h0100);
    duty(16'($random(seed)));
    give_verdict;
  end
  // whole run is near five thousand clocks
  initial begin
    #1000000;
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
